// file: verilog/trap_irq_map.vh
// Purpose: Offsets, field positions, reset values and codes of the
//          trap and port edge interrupt logic.
// Assumes: AHB-Lite slave with 32-bit data, one register per word.
// Notes:   Definitions only.
`ifndef TRAP_IRQ_MAP_VH
`define TRAP_IRQ_MAP_VH

// Register byte offsets
`define OFF_CTRL         8'h00
`define OFF_EDGE_EN      8'h04
`define OFF_EDGE_POL     8'h08
`define OFF_EDGE_PEND    8'h0C
`define OFF_STATUS       8'h10

// Control register fields
`define CTRL_GIE_BIT     0
`define CTRL_GRP_EN_BIT  1

// Status register fields
`define ST_REQ_BIT       0
`define ST_WAKE_BIT      1
`define ST_BOOT_BIT      2
`define ST_TRAP_SVC_BIT  3
`define ST_MASK_SVC_BIT  4

// Reset values
`define RST_CTRL         2'h0
`define RST_BYTE         8'h00

// Opcode and address codes
`define TRAP_OPCODE      8'h00
`define STACK_LIMIT      8'h6F
`define OVERPOP_PC       15'h7FFF
`define VEC_TRAP         8'hFE
`define VEC_PORT_EDGE    8'hE2
`define VEC_DEFAULT      8'hE0

`endif

// file: verilog/fetch_guard.v
// Purpose: Opcode fetch guard and next-pc selection on stack overpop.
// Assumes: Program memory is programmed up to prog_limit.
// Notes:   Returns all-zero opcode beyond the programmed space.
`timescale 1ns/1ps
`default_nettype none
`include "trap_irq_map.vh"

module fetch_guard (
   input  wire [14:0] fetch_addr,   // Address being fetched
   input  wire [7:0]  mem_data,     // Raw program memory byte
   input  wire [14:0] prog_limit,   // Last programmed address
   input  wire        pop,          // Stack pop this cycle
   input  wire [7:0]  sp_before,    // Stack pointer before pop
   input  wire [14:0] pop_pc,       // Address popped from stack
   output wire [7:0]  fetch_data,   // Guarded opcode byte
   output wire [14:0] ret_pc        // Pc loaded after pop
);
   wire overpop;
   assign overpop = pop && (sp_before >= `STACK_LIMIT);
   assign ret_pc  = overpop ? `OVERPOP_PC : pop_pc; // RULE7
   // Unprogrammed space and the overpop cell read as the trap opcode
   assign fetch_data = ((fetch_addr > prog_limit) ||
                        (fetch_addr == `OVERPOP_PC)) ?
                       `TRAP_OPCODE : mem_data; // RULE6 RULE7
endmodule // fetch_guard
`default_nettype wire

// file: verilog/edge_detect.v
// Purpose: Synchronise one port pin and flag a qualifying edge.
// Assumes: Pin is asynchronous to the core clock.
// Notes:   Pulse is one cycle per qualifying edge.
`timescale 1ns/1ps
`default_nettype none

module edge_detect (
   input  wire clock,     // Core clock
   input  wire rst_n,     // Synchronised reset
   input  wire pin,       // Port pin
   input  wire rising,    // 1 selects rising, 0 falling
   output wire hit        // One-cycle edge pulse
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin; // RULE23
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign hit = rising ? (s2_r & ~s3_r) : (~s2_r & s3_r); // RULE15
endmodule // edge_detect
`default_nettype wire

// file: verilog/trap_edge_irq.v
// Purpose: Software trap pending flag and eight port edge interrupts,
//          with request and vector outputs for the sequencer.
// Assumes: Sequencer pulses op strobes for one cycle per instruction.
// Notes:   Operation
// Operation
// RULE1: Device reset clears the trap pending flag.
// RULE2: A trap sets the trap pending flag.
// RULE3: Only the clear-trap instruction or reset clears the flag.
// RULE4: Trap pending flag is not in the register map.
// RULE5: Trap opcode 00 loaded into instruction register raises a trap.
// RULE6: Fetches beyond programmed memory return zero.
// RULE7: Pop past 06F loads 7FFF; fetch there returns zero.
// RULE8: Trap leaves global enable alone and blocks maskable acknowledges.
// RULE9: Trap wins arbitration and vectors to its routine.
// RULE10: Only another trap interrupts a trap service routine.
// RULE11: Trap return address is the trap opcode's own address.
// RULE12: Trap is acknowledged at once.
// RULE13: Eight edge inputs share one vector.
// RULE14: Each edge interrupt has its own enable bit.
// RULE15: Polarity bit picks rising or falling edge per pin.
// RULE16: Edges latch per-pin pending bits; no group pending flag.
// RULE17: Port request needs group enable and global enable.
// RULE18: Port edge wakes from halt; service first only if enabled.
// RULE19: Maskable routines are preempted only by the trap.
// RULE20: Boot ROM suppresses interrupts, global enable untouched; the code gates only mask_req and wake_service, and trap_req is not gated.
// RULE21: Repeat events of a pending source are dropped in boot ROM.
// RULE22: Trap selected gives low pc byte FE.
// RULE23: Edge inputs are synchronised before detection.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "trap_irq_map.vh"

module trap_edge_irq (
   input  wire        clock,        // Core clock 40 MHz
   input  wire        arst_n,       // Asynchronous reset, low
   input  wire [31:0] haddr,        // AHB address
   input  wire [1:0]  htrans,       // AHB transfer type
   input  wire        hwrite,       // AHB write
   input  wire [2:0]  hsize,        // AHB size
   input  wire [31:0] hwdata,       // AHB write data
   input  wire        hsel,         // AHB select
   input  wire        hready,       // AHB ready in
   output reg  [31:0] hrdata,       // AHB read data
   output reg         hreadyout,    // AHB ready out
   output reg         hresp,        // AHB response
   input  wire [7:0]  port_pins,    // Port edge pins
   input  wire        ir_load,      // Instruction register load
   input  wire [7:0]  fetch_mem,    // Raw program memory byte
   input  wire [14:0] fetch_addr,   // Address of fetched byte
   input  wire [14:0] prog_limit,   // Last programmed address
   input  wire        stack_pop,    // Stack pop strobe
   input  wire [7:0]  sp_value,     // Stack pointer before pop
   input  wire [14:0] pop_addr,     // Popped address
   input  wire        clear_trap_pending_op, // Clear-trap instruction
   input  wire        vector_select_op,      // Vector select, 1st cycle
   input  wire        return_from_irq_op,    // Return from interrupt
   input  wire        return_and_skip_op,    // Return and skip
   input  wire        boot_rom_programming,  // Running from boot ROM
   input  wire        halted,       // Halt or idle mode
   output reg  [7:0]  ir_opcode,    // Guarded opcode into IR
   output reg  [14:0] trap_ret_addr, // Address pushed by trap
   output reg  [14:0] pc_after_pop, // Pc after stack pop
   output reg         trap_req,     // Trap request to sequencer
   output reg         mask_req,     // Maskable request to sequencer
   output reg  [7:0]  vector_low,   // Low pc byte from arbitration
   output reg         wake,         // Wake from halt or idle
   output reg         wake_service  // Run service routine on wake
);
   // Reset release through two flops
   reg rs1_r;
   reg rst_n;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rs1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_n <= rs1_r;
      end
   end

   reg        trap_pending_flag;
   reg        global_irq_enable;
   reg        port_group_irq_enable;
   reg [7:0]  port_edge_enable_reg;
   reg [7:0]  port_edge_polarity_reg;
   reg [7:0]  port_edge_pending_reg;
   reg        trap_svc_r;
   reg        mask_svc_r;

   wire [7:0]  guarded_op;
   wire [14:0] next_pc;
   wire [7:0]  hits;

   fetch_guard u_guard (
      .fetch_addr (fetch_addr),
      .mem_data   (fetch_mem),
      .prog_limit (prog_limit),
      .pop        (stack_pop),
      .sp_before  (sp_value),
      .pop_pc     (pop_addr),
      .fetch_data (guarded_op),
      .ret_pc     (next_pc)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : pin_gen
         edge_detect u_edge (
            .clock  (clock),
            .rst_n  (rst_n),
            .pin    (port_pins[g]),
            .rising (port_edge_polarity_reg[g]),
            .hit    (hits[g])
         );
      end
   endgenerate

   // Trap raised when the zero opcode enters the instruction register
   wire trap_event;
   assign trap_event = ir_load && (guarded_op == `TRAP_OPCODE); // RULE5

   // AHB address phase capture
   reg       wr_pend_r;
   reg [7:0] wr_addr_r;
   wire      sel_ok;
   assign sel_ok = hsel && hready && htrans[1];

   function [31:0] read_mux;
      input [7:0] a;
      begin
         case (a)
            `OFF_CTRL:      read_mux = {30'h0000_0000,
                                        port_group_irq_enable,
                                        global_irq_enable};
            `OFF_EDGE_EN:   read_mux = {24'h00_0000, port_edge_enable_reg};
            `OFF_EDGE_POL:  read_mux = {24'h00_0000,
                                        port_edge_polarity_reg};
            `OFF_EDGE_PEND: read_mux = {24'h00_0000,
                                        port_edge_pending_reg};
            `OFF_STATUS:    read_mux = {27'h000_0000, mask_svc_r,
                                        trap_svc_r, boot_rom_programming,
                                        wake, mask_req}; // RULE4
            default:        read_mux = 32'h0000_0000;
         endcase
      end
   endfunction

   wire wr_ctrl;
   wire wr_en;
   wire wr_pol;
   wire wr_pend;
   assign wr_ctrl = wr_pend_r && (wr_addr_r == `OFF_CTRL);
   assign wr_en   = wr_pend_r && (wr_addr_r == `OFF_EDGE_EN);
   assign wr_pol  = wr_pend_r && (wr_addr_r == `OFF_EDGE_POL);
   assign wr_pend = wr_pend_r && (wr_addr_r == `OFF_EDGE_PEND);

   // Maskable request and vector selection
   wire [7:0] port_active;
   wire       port_ok;
   assign port_active = port_edge_pending_reg & port_edge_enable_reg;
   assign port_ok = (|port_active) && port_group_irq_enable &&
                    global_irq_enable; // RULE13 RULE17
   wire mask_ok;
   assign mask_ok = port_ok && !trap_pending_flag && !trap_svc_r &&
                    !mask_svc_r && !boot_rom_programming;
                    // RULE8 RULE10 RULE19 RULE20

   // Pending bits: set wins over software clear (write 1 to clear)
   wire [7:0] pend_nxt;
   generate
      for (g = 0; g < 8; g = g + 1) begin : pend_gen
         wire set_b;
         assign set_b = hits[g] && port_edge_enable_reg[g]; // RULE14
         assign pend_nxt[g] = set_b ? 1'b1 :
                  ((wr_pend && hwdata[g]) ? 1'b0 :
                   port_edge_pending_reg[g]); // RULE16 RULE21
      end
   endgenerate

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trap_pending_flag      <= 1'b0; // RULE1
         global_irq_enable      <= 1'b0;
         port_group_irq_enable  <= 1'b0;
         port_edge_enable_reg   <= `RST_BYTE;
         port_edge_polarity_reg <= `RST_BYTE;
         port_edge_pending_reg  <= `RST_BYTE;
         trap_svc_r             <= 1'b0;
         mask_svc_r             <= 1'b0;
         wr_pend_r              <= 1'b0;
         wr_addr_r              <= 8'h00;
         hrdata                 <= 32'h0000_0000;
         hreadyout              <= 1'b1;
         hresp                  <= 1'b0;
         ir_opcode              <= 8'h00;
         trap_ret_addr          <= 15'h0000;
         pc_after_pop           <= 15'h0000;
         trap_req               <= 1'b0;
         mask_req               <= 1'b0;
         vector_low             <= `VEC_DEFAULT;
         wake                   <= 1'b0;
         wake_service           <= 1'b0;
      end else begin
         // Bus: zero-wait slave, OKAY always, unmapped reads zero
         wr_pend_r <= sel_ok && hwrite;
         wr_addr_r <= haddr[7:0];
         if (sel_ok && !hwrite)
            hrdata <= read_mux(haddr[7:0]);
         if (wr_ctrl) begin
            global_irq_enable     <= hwdata[`CTRL_GIE_BIT];
            port_group_irq_enable <= hwdata[`CTRL_GRP_EN_BIT];
         end
         if (wr_en)
            port_edge_enable_reg <= hwdata[7:0];
         if (wr_pol)
            port_edge_polarity_reg <= hwdata[7:0];
         port_edge_pending_reg <= pend_nxt;

         // Trap flag: set wins over the clear instruction
         if (trap_event)
            trap_pending_flag <= 1'b1; // RULE2 RULE8
         else if (clear_trap_pending_op)
            trap_pending_flag <= 1'b0; // RULE3

         // Service context tracking
         if (vector_select_op && (trap_pending_flag || trap_event))
            trap_svc_r <= 1'b1;
         else if (return_from_irq_op || return_and_skip_op)
            trap_svc_r <= 1'b0;
         if (vector_select_op && !trap_pending_flag && mask_ok)
            mask_svc_r <= 1'b1;
         else if (return_from_irq_op || return_and_skip_op)
            mask_svc_r <= 1'b0;

         // Both hold their value until the next load or pop strobe
         if (ir_load)
            ir_opcode <= guarded_op; // RULE5
         if (stack_pop)
            pc_after_pop <= next_pc; // RULE7
         if (trap_event)
            trap_ret_addr <= fetch_addr; // RULE11
         trap_req <= trap_event || trap_pending_flag; // RULE12
         mask_req <= mask_ok;

         if (vector_select_op) begin
            if (trap_pending_flag || trap_event)
               vector_low <= `VEC_TRAP; // RULE9 RULE22
            else if (mask_ok)
               vector_low <= `VEC_PORT_EDGE;
            else
               vector_low <= `VEC_DEFAULT;
         end

         wake         <= halted && (|port_active); // RULE18
         wake_service <= halted && port_ok && !boot_rom_programming;
      end
   end
endmodule // trap_edge_irq
`default_nettype wire

// file: verif/seq_model.sv
// Purpose: Sequencer side model driving fetch, pop and op strobes.
// Assumes: Strobes are one-cycle pulses launched after a rising edge.
// Notes:   Idle fetch byte shows the inverse of the last one.
`timescale 1ns/1ps
`default_nettype none
module seq_model (
   input  wire logic        clock,      // Core clock
   output var  logic        ir_load,    // IR load strobe
   output var  logic [7:0]  fetch_mem,  // Program byte
   output var  logic [14:0] fetch_addr, // Fetch address
   output var  logic        stack_pop,  // Pop strobe
   output var  logic [7:0]  sp_value,   // SP before pop
   output var  logic [14:0] pop_addr,   // Popped address
   output var  logic [3:0]  ops         // Clear, select, return_from_irq_op, return_and_skip_op
);
   initial begin
      ir_load = 1'b0;
      fetch_mem = 8'h00;
      fetch_addr = 15'h0000;
      stack_pop = 1'b0;
      sp_value = 8'h00;
      pop_addr = 15'h0000;
      ops = 4'h0;
   end
   task automatic fetch(input logic [14:0] a, input logic [7:0] d);
      @(posedge clock);
      ir_load <= 1'b1;
      fetch_addr <= a;
      fetch_mem <= d;
      @(posedge clock);
      ir_load <= 1'b0;
      fetch_mem <= ~d;
      fetch_addr <= ~a;
   endtask
   task automatic pop(input logic [7:0] s, input logic [14:0] a);
      @(posedge clock);
      stack_pop <= 1'b1;
      sp_value <= s;
      pop_addr <= a;
      @(posedge clock);
      stack_pop <= 1'b0;
      sp_value <= ~s;
      pop_addr <= ~a;
   endtask
   task automatic op(input int i);
      @(posedge clock);
      ops[i] <= 1'b1;
      @(posedge clock);
      ops[i] <= 1'b0;
   endtask
endmodule // seq_model
`default_nettype wire

// file: verif/trap_edge_irq_asserts.sv
// Purpose: Concurrent checks on the trap and port edge outputs.
// Assumes: Bound to trap_edge_irq, watching its ports only.
// Notes:   Disabled while arst_n is low.
`timescale 1ns/1ps
`default_nettype none
`include "trap_irq_map.vh"
module trap_edge_irq_asserts (
   input wire logic        clock,         // Clock
   input wire logic        arst_n,        // Reset
   input wire logic        ir_load,       // IR load
   input wire logic [7:0]  fetch_mem,     // Raw byte
   input wire logic [14:0] fetch_addr,    // Fetch address
   input wire logic [14:0] prog_limit,    // Last address
   input wire logic        stack_pop,     // Pop
   input wire logic [7:0]  sp_value,      // SP
   input wire logic [14:0] pop_addr,      // Popped address
   input wire logic        clear_trap_pending_op, // Clear op
   input wire logic        vector_select_op,      // Select op
   input wire logic        boot_rom_programming,  // Boot ROM
   input wire logic        halted,        // Halt
   input wire logic [7:0]  ir_opcode,     // IR
   input wire logic [14:0] trap_ret_addr, // Return address
   input wire logic [14:0] pc_after_pop,  // Pc after pop
   input wire logic        trap_req,      // Trap request
   input wire logic        mask_req,      // Maskable request
   input wire logic [7:0]  vector_low,    // Vector byte
   input wire logic        wake,          // Wake
   input wire logic        wake_service   // Wake to service
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence bad_fetch_s;
      ir_load && (fetch_addr > prog_limit || fetch_addr == `OVERPOP_PC);
   endsequence
   sequence good_fetch_s;
      ir_load && fetch_addr <= prog_limit && fetch_addr != `OVERPOP_PC;
   endsequence
   guard_zero_a: assert property (
      bad_fetch_s |=> ir_opcode == `TRAP_OPCODE)
      else $error("guarded fetch not zero");
   guard_pass_a: assert property (
      good_fetch_s |=> ir_opcode == $past(fetch_mem))
      else $error("fetched byte altered");
   trap_raise_a: assert property (
      bad_fetch_s |=> ##[0:1] trap_req)
      else $error("trap not raised");
   ret_addr_a: assert property (
      bad_fetch_s |=> trap_ret_addr == $past(fetch_addr))
      else $error("wrong trap return address");
   pop_over_a: assert property (
      stack_pop && sp_value >= `STACK_LIMIT |=> pc_after_pop == `OVERPOP_PC)
      else $error("overpop pc wrong");
   pop_norm_a: assert property (
      stack_pop && sp_value < `STACK_LIMIT |=> pc_after_pop == $past(pop_addr))
      else $error("pop pc wrong");
   trap_hold_a: assert property (
      trap_req && !clear_trap_pending_op && !$past(clear_trap_pending_op)
      |=> trap_req) else $error("trap flag lost");
   trap_vec_a: assert property (
      vector_select_op && trap_req && !$past(clear_trap_pending_op)
      |=> vector_low == `VEC_TRAP) else $error("trap vector wrong");
   boot_quiet_a: assert property (
      boot_rom_programming && $past(boot_rom_programming)
      |-> !mask_req && !wake_service) else $error("irq in boot ROM");
   wake_halt_a: assert property (
      !halted && !$past(halted) |-> !wake && !wake_service)
      else $error("wake while running");
endmodule // trap_edge_irq_asserts
`default_nettype wire

// file: verif/trap_edge_irq_test.sv
// Purpose: Self-checking bench for the trap and port edge logic.
// Assumes: Single AHB-Lite master; hreadyout feeds hready.
// Notes:   Sequencer strobes come from seq_model.
`timescale 1ns/1ps
`default_nettype none
`include "trap_irq_map.vh"
module trap_edge_irq_test;
   logic        clock, arst_n, hwrite, hsel, boot, halted;
   logic [31:0] haddr, hwdata, v;
   logic [1:0]  htrans;
   logic [7:0]  pins;
   logic [14:0] limit;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, ir_load, stack_pop, trap_req, mask_req;
   wire         wake, wake_service;
   wire  [7:0]  fetch_mem, sp_value, ir_opcode, vector_low;
   wire  [14:0] fetch_addr, pop_addr, trap_ret_addr, pc_after_pop;
   wire  [3:0]  ops;
   int          fail_count, n_compared;
   seq_model SEQ (.clock, .ir_load, .fetch_mem, .fetch_addr, .stack_pop,
      .sp_value, .pop_addr, .ops);
   trap_edge_irq DUT (.clock, .arst_n, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hsel, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .port_pins(pins), .ir_load, .fetch_mem,
      .fetch_addr, .prog_limit(limit), .stack_pop, .sp_value, .pop_addr,
      .clear_trap_pending_op(ops[0]), .vector_select_op(ops[1]),
      .return_from_irq_op(ops[2]), .return_and_skip_op(ops[3]),
      .boot_rom_programming(boot), .halted, .ir_opcode, .trap_ret_addr,
      .pc_after_pop, .trap_req, .mask_req, .vector_low, .wake,
      .wake_service);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0000_00, a};
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      v = hrdata;
   endtask
   task automatic rd(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, v, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic pin_step(input logic [7:0] p);
      @(posedge clock);
      pins <= p;
      tick(4);
   endtask
   task automatic mode(input logic b, h, input int n);
      @(posedge clock);
      {boot, halted} <= {b, h};
      tick(n);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      print_verdict;
   end
   initial begin
      arst_n = 1'b0;
      {hsel, hwrite, boot, halted} = 4'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      pins = 8'h00;
      limit = 15'h1234;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      tick(4);
      chk("trap_req", trap_req, 0);
      chk("vector_low", vector_low, `VEC_DEFAULT);
      rd("pending", `OFF_EDGE_PEND, 0);
      xfer(1'b1, `OFF_EDGE_EN, 32'h0000_0003);
      xfer(1'b1, `OFF_EDGE_POL, 32'h0000_0001);
      xfer(1'b1, `OFF_CTRL, 32'h0000_0003);
      pin_step(8'h07);
      rd("pending", `OFF_EDGE_PEND, 32'h0000_0001);
      pin_step(8'h00);
      rd("pending", `OFF_EDGE_PEND, 32'h0000_0003);
      pin_step(8'h01);
      rd("pending", `OFF_EDGE_PEND, 32'h0000_0003);
      chk("mask_req", mask_req, 1);
      for (int i = 1; i < 3; i++) begin
         xfer(1'b1, `OFF_CTRL, i);
         tick(2);
         chk("mask_req", mask_req, 0);
      end
      xfer(1'b1, `OFF_CTRL, 32'h0000_0003);
      mode(1'b1, 1'b0, 3);
      chk("mask_req", mask_req, 0);
      rd("ctrl", `OFF_CTRL, 32'h0000_0003);
      mode(1'b0, 1'b1, 3);
      chk("mask_req", mask_req, 1);
      chk("wake", {wake, wake_service}, 2'b11);
      xfer(1'b1, `OFF_CTRL, 32'h0000_0001);
      tick(2);
      chk("wake", {wake, wake_service}, 2'b10);
      mode(1'b0, 1'b0, 0);
      xfer(1'b1, `OFF_CTRL, 32'h0000_0003);
      SEQ.op(1);
      tick(1);
      chk("vector_low", vector_low, `VEC_PORT_EDGE);
      SEQ.fetch(15'h1235, 8'hAA);
      tick(1);
      chk("ir_opcode", ir_opcode, `TRAP_OPCODE);
      chk("trap_ret_addr", trap_ret_addr, 15'h1235);
      tick(2);
      chk("trap_req", trap_req, 1);
      chk("mask_req", mask_req, 0);
      rd("ctrl", `OFF_CTRL, 32'h0000_0003);
      rd("unmapped", 8'h14, 0);
      chk("bus response", {hreadyout, hresp}, 2'b10);
      SEQ.op(1);
      tick(1);
      chk("vector_low", vector_low, `VEC_TRAP);
      chk("mask_req", mask_req, 0);
      rd("status", `OFF_STATUS, 32'h0000_0018);
      SEQ.op(3);
      tick(3);
      chk("trap_req", trap_req, 1);
      SEQ.op(0);
      tick(3);
      chk("trap_req", trap_req, 0);
      SEQ.op(2);
      tick(2);
      chk("mask_req", mask_req, 1);
      SEQ.fetch(15'h0100, 8'h5A);
      tick(1);
      chk("ir_opcode", ir_opcode, 8'h5A);
      tick(2);
      chk("trap_req", trap_req, 0);
      @(posedge clock);
      limit <= 15'h7FFF;
      SEQ.fetch(15'h7FFF, 8'hC3);
      tick(1);
      chk("ir_opcode", ir_opcode, `TRAP_OPCODE);
      SEQ.op(0);
      SEQ.pop(8'h6F, 15'h0222);
      tick(1);
      chk("pc_after_pop", pc_after_pop, `OVERPOP_PC);
      SEQ.pop(8'h6E, 15'h0333);
      tick(1);
      chk("pc_after_pop", pc_after_pop, 15'h0333);
      xfer(1'b1, `OFF_EDGE_PEND, 32'h0000_0001);
      rd("pending", `OFF_EDGE_PEND, 32'h0000_0002);
      SEQ.fetch(15'h7FFF, 8'h7E);
      tick(1);
      chk("trap_req", trap_req, 1);
      arst_n <= 1'b0;
      tick(2);
      chk("trap_req", trap_req, 0);
      @(posedge clock);
      arst_n <= 1'b1;
      tick(3);
      chk("trap_req", trap_req, 0);
      chk("vector_low", vector_low, `VEC_DEFAULT);
      print_verdict;
   end
endmodule // trap_edge_irq_test
bind trap_edge_irq trap_edge_irq_asserts CHK (.clock, .arst_n, .ir_load,
   .fetch_mem, .fetch_addr, .prog_limit, .stack_pop, .sp_value, .pop_addr,
   .clear_trap_pending_op, .vector_select_op, .boot_rom_programming,
   .halted, .ir_opcode, .trap_ret_addr, .pc_after_pop, .trap_req,
   .mask_req, .vector_low, .wake, .wake_service);
`default_nettype wire
